// ---- shared/tcie_pkg.sv ----
// Constants, register map and carrier types for the timer channel interrupt enable bank
package tcie_pkg;

   localparam int          TCIE_NCH        = 5;
   localparam int          TCIE_CNT_W      = 16;
   localparam int          TCIE_ADDR_W     = 8;
   localparam int          TCIE_REG_W      = 8;

   // Byte addresses of the register words
   localparam logic [7:0]  TCIE_ENA_BASE   = 8'h00;
   localparam logic [7:0]  TCIE_STS_BASE   = 8'h20;
   localparam logic [7:0]  TCIE_EVT_STS    = 8'h40;
   localparam logic [7:0]  TCIE_EVT_MASK   = 8'h44;
   localparam logic [7:0]  TCIE_WORD_STEP  = 8'h04;

   // Enable register fields
   localparam int          TCIE_B_CONV     = 7;
   localparam int          TCIE_B_RSVD1    = 6;
   localparam int          TCIE_B_UNF      = 5;
   localparam int          TCIE_B_OVF      = 4;
   localparam int          TCIE_B_MD       = 3;
   localparam int          TCIE_B_MC       = 2;
   localparam int          TCIE_B_MB       = 1;
   localparam int          TCIE_B_MA       = 0;

   // Implemented bits per channel group, and fixed read values
   localparam logic [7:0]  TCIE_ENA_MASK_UD  = 8'hB3;
   localparam logic [7:0]  TCIE_ENA_MASK_MAT = 8'h9F;
   localparam logic [7:0]  TCIE_FLG_MASK_UD  = 8'h33;
   localparam logic [7:0]  TCIE_FLG_MASK_MAT = 8'h1F;
   localparam logic [7:0]  TCIE_ENA_RST      = 8'h00;
   localparam logic [7:0]  TCIE_ENA_FIXED1   = 8'h40;
   localparam logic [7:0]  TCIE_STS_FIXED1   = 8'hC0;
   localparam logic [5:0]  TCIE_FLG_RST      = 6'h00;

   localparam logic [15:0] TCIE_CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] TCIE_CNT_ZERO   = 16'h0000;

   localparam logic [1:0]  TCIE_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  TCIE_RESP_DEC   = 2'h3;

   // Event status: bit per channel request rise, top bit for converter start
   localparam int          TCIE_EVT_W      = 6;
   localparam int          TCIE_EVT_CONV   = 5;
   localparam logic [5:0]  TCIE_EVT_RST    = 6'h00;

   // One interrupt request group, order matches enable bits 5..0
   typedef struct packed {
      logic unf;
      logic ovf;
      logic md;
      logic mc;
      logic mb;
      logic ma;
   } tcie_req_s;

   // Capture/compare events of one channel
   typedef struct packed {
      logic md;
      logic mc;
      logic mb;
      logic ma;
   } tcie_match_s;

endpackage : tcie_pkg

// ---- logic/tcie_top.sv ----
// Timer channel interrupt and converter-trigger enable bank with AXI4-Lite slave
`timescale 1ns/1ps
// Function
// - One 8-bit read/write enable register per channel, five channels
// - Bit 7 gates channel-A converter start request
// - Bit 6 reserved, reads 1, writes ignored
// - Channels 1,2 bit 5 enables underflow request
// - Channels 0,3,4 bit 5 reads 0
// - Bit 4 enables overflow request everywhere
// - Channels 0,3,4 bit 3 enables match D
// - Channels 1,2 bit 3 reads 0
// - Channels 0,3,4 bit 2 enables match C
// - Channels 1,2 bit 2 reads 0
// - Bit 1 enables match B request
// - Bit 0 enables match A request
// - Overflow on max-to-zero, underflow zero-to-max
module tcie_top
   import tcie_pkg::*;
#(
   parameter int NCH   = TCIE_NCH,
   parameter int CNT_W = TCIE_CNT_W
)
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [TCIE_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [TCIE_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   input  wire logic [CNT_W-1:0]       channel_counter [NCH],
   input  wire tcie_match_s            match_evt       [NCH],
   output tcie_req_s                   irq_req         [NCH],
   output logic [NCH-1:0]              conv_start_req,
   output logic                        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Channels 1 and 2 carry the underflow bit; the others carry match C/D
   function automatic logic is_ud_chan(input int ch);
      is_ud_chan = (ch == 1) || (ch == 2);
   endfunction : is_ud_chan

   function automatic logic [7:0] ena_mask(input int ch);
      ena_mask = is_ud_chan(ch) ? TCIE_ENA_MASK_UD : TCIE_ENA_MASK_MAT;
   endfunction : ena_mask

   function automatic logic [7:0] flg_mask(input int ch);
      flg_mask = is_ud_chan(ch) ? TCIE_FLG_MASK_UD : TCIE_FLG_MASK_MAT;
   endfunction : flg_mask

   // Returns channel index of an address in a block of NCH words, or -1
   function automatic int chan_of(input logic [TCIE_ADDR_W-1:0] addr, input logic [7:0] base);
      chan_of = -1;
      for (int i = 0; i < NCH; i++)
      begin
         if (addr == 8'(base + 8'(i) * TCIE_WORD_STEP))
         begin
            chan_of = i;
         end
      end
   endfunction : chan_of

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]            ena_ff   [NCH];
   logic [5:0]            flag_ff  [NCH];
   logic [5:0]            armed_ff [NCH];
   logic [CNT_W-1:0]      cnt_prev_ff [NCH];
   logic                  cnt_vld_ff;
   logic [TCIE_EVT_W-1:0] evt_sts_ff;
   logic [TCIE_EVT_W-1:0] evt_mask_ff;

   logic                   aw_held_ff;
   logic                   w_held_ff;
   logic [TCIE_ADDR_W-1:0] awaddr_ff;
   logic [7:0]             wbyte_ff;
   logic                   wlane_ff;

   logic [5:0]      set_evt  [NCH];
   logic [NCH-1:0]  req_rise;
   logic            wr_fire;
   logic            rd_fire;
   int              wr_ena_ch;
   int              wr_sts_ch;
   int              rd_ena_ch;
   int              rd_sts_ch;

   assign wr_fire   = aw_held_ff && w_held_ff && !s_axi_bvalid;
   assign rd_fire   = s_axi_arvalid && s_axi_arready;
   assign wr_ena_ch = chan_of(awaddr_ff, TCIE_ENA_BASE);
   assign wr_sts_ch = chan_of(awaddr_ff, TCIE_STS_BASE);
   assign rd_ena_ch = chan_of(s_axi_araddr, TCIE_ENA_BASE);
   assign rd_sts_ch = chan_of(s_axi_araddr, TCIE_STS_BASE);

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff    <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_ff     <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_ff    <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_ff     <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         aw_held_ff <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_ff    <= 1'b0;
         s_axi_wready <= 1'b0;
         wbyte_ff     <= '0;
         wlane_ff     <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_ff    <= 1'b1;
         s_axi_wready <= 1'b0;
         wbyte_ff     <= s_axi_wdata[7:0];
         wlane_ff     <= s_axi_wstrb[0];
      end
      else if (wr_fire)
      begin
         w_held_ff <= 1'b0;
      end
      else
      begin
         s_axi_wready <= !w_held_ff && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TCIE_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (wr_ena_ch >= 0 || wr_sts_ch >= 0 || awaddr_ff == TCIE_EVT_STS || awaddr_ff == TCIE_EVT_MASK)
         begin
            s_axi_bresp <= TCIE_RESP_OKAY;
         end
         else
         begin
            s_axi_bresp <= TCIE_RESP_DEC;
         end
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable registers

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            ena_ff[c] <= TCIE_ENA_RST;
         end
      end
      else if (wr_fire && wlane_ff && wr_ena_ch >= 0)
      begin
         // Reserved positions never store, so they read back fixed
         ena_ff[wr_ena_ch] <= wbyte_ff & ena_mask(wr_ena_ch);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags: counter wrap detection and match capture

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_vld_ff <= 1'b0;
         for (int c = 0; c < NCH; c++)
         begin
            cnt_prev_ff[c] <= '0;
         end
      end
      else
      begin
         cnt_vld_ff <= 1'b1;
         for (int c = 0; c < NCH; c++)
         begin
            cnt_prev_ff[c] <= channel_counter[c];
         end
      end
   end

   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         set_evt[c]    = '0;
         set_evt[c][TCIE_B_OVF] = cnt_vld_ff && cnt_prev_ff[c] == TCIE_CNT_MAX
                                  && channel_counter[c] == TCIE_CNT_ZERO;
         set_evt[c][TCIE_B_UNF] = cnt_vld_ff && cnt_prev_ff[c] == TCIE_CNT_ZERO
                                  && channel_counter[c] == TCIE_CNT_MAX;
         set_evt[c][TCIE_B_MD]  = match_evt[c].md;
         set_evt[c][TCIE_B_MC]  = match_evt[c].mc;
         set_evt[c][TCIE_B_MB]  = match_evt[c].mb;
         set_evt[c][TCIE_B_MA]  = match_evt[c].ma;
         set_evt[c] = set_evt[c] & 6'(flg_mask(c));
      end
   end

   // A flag is armed by a read that saw it high; only then does a written 0 clear it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            armed_ff[c] <= TCIE_FLG_RST;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (rd_fire && rd_sts_ch == c)
            begin
               armed_ff[c] <= flag_ff[c];
            end
            else if (wr_fire && wlane_ff && wr_sts_ch == c)
            begin
               armed_ff[c] <= armed_ff[c] & wbyte_ff[5:0];
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            flag_ff[c] <= TCIE_FLG_RST;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            // Set wins over a clear in the same cycle; writing 1 has no effect
            if (wr_fire && wlane_ff && wr_sts_ch == c)
            begin
               flag_ff[c] <= (flag_ff[c] & ~(armed_ff[c] & ~wbyte_ff[5:0])) | set_evt[c];
            end
            else
            begin
               flag_ff[c] <= flag_ff[c] | set_evt[c];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request outputs and converter trigger

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            irq_req[c] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            irq_req[c] <= tcie_req_s'(flag_ff[c] & ena_ff[c][5:0]);
         end
      end
   end

   // Pulse follows the match-A event itself, not the sticky flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         conv_start_req <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            conv_start_req[c] <= match_evt[c].ma && ena_ff[c][TCIE_B_CONV];
         end
      end
   end

   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         req_rise[c] = |(flag_ff[c] & ena_ff[c][5:0] & ~6'(irq_req[c]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Summary interrupt: sticky events, write-one-to-clear, mask

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_sts_ff  <= TCIE_EVT_RST;
         evt_mask_ff <= TCIE_EVT_RST;
      end
      else
      begin
         if (wr_fire && wlane_ff && awaddr_ff == TCIE_EVT_MASK)
         begin
            evt_mask_ff <= wbyte_ff[TCIE_EVT_W-1:0];
         end
         if (wr_fire && wlane_ff && awaddr_ff == TCIE_EVT_STS)
         begin
            evt_sts_ff <= (evt_sts_ff & ~wbyte_ff[TCIE_EVT_W-1:0]) | {|conv_start_req, 5'(req_rise)};
         end
         else
         begin
            evt_sts_ff <= evt_sts_ff | {|conv_start_req, 5'(req_rise)};
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(evt_sts_ff & evt_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= TCIE_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= TCIE_RESP_OKAY;
         s_axi_rdata   <= '0;
         if (rd_ena_ch >= 0)
         begin
            s_axi_rdata[7:0] <= ena_ff[rd_ena_ch] | TCIE_ENA_FIXED1;
         end
         else if (rd_sts_ch >= 0)
         begin
            s_axi_rdata[7:0] <= {2'b00, flag_ff[rd_sts_ch]} | TCIE_STS_FIXED1;
         end
         else if (s_axi_araddr == TCIE_EVT_STS)
         begin
            s_axi_rdata[TCIE_EVT_W-1:0] <= evt_sts_ff;
         end
         else if (s_axi_araddr == TCIE_EVT_MASK)
         begin
            s_axi_rdata[TCIE_EVT_W-1:0] <= evt_mask_ff;
         end
         else
         begin
            s_axi_rresp <= TCIE_RESP_DEC;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end

endmodule : tcie_top

// ---- test/tcie_assertions.sv ----
// Port-level concurrent checks for the timer interrupt enable bank
`timescale 1ns/1ps
module tcie_assertions
   import tcie_pkg::*;
#(
   parameter int NCH = TCIE_NCH
)
(
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [TCIE_ADDR_W-1:0] s_axi_araddr,
   input wire logic                   s_axi_rvalid,
   input wire logic [31:0]            s_axi_rdata,
   input wire tcie_match_s            match_evt      [NCH],
   input wire tcie_req_s              irq_req        [NCH],
   input wire logic [NCH-1:0]         conv_start_req
);
   logic [7:0] rd_addr_ff;
   logic       rd_ena;
   logic       rd_ud;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////
   // Address of the read in flight, so read data can be judged per channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rd_addr_ff <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready)
         rd_addr_ff <= s_axi_araddr;
   end

   assign rd_ena = (rd_addr_ff < 8'h14);
   assign rd_ud  = (rd_addr_ff[4:2] == 3'h1) || (rd_addr_ff[4:2] == 3'h2);

   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   sequence s_ena_data;
      s_axi_rvalid && rd_ena;
   endsequence

   ////////////////////////////////////////////////////////////
   AST_RD_LAT: assert property (s_ar_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data late or wider than one byte");
   AST_RSVD6: assert property (s_ena_data |-> s_axi_rdata[6])
      else $error("enable bit 6 not read as one");
   AST_RSVD5: assert property (s_ena_data and !rd_ud |-> !s_axi_rdata[5])
      else $error("enable bit 5 set in a match channel");
   AST_RSVD32: assert property (s_ena_data and rd_ud |-> s_axi_rdata[3:2] == 2'h0)
      else $error("enable bits 3..2 set in an up/down channel");
   AST_NO_UNF: assert property (!irq_req[0].unf && !irq_req[3].unf && !irq_req[4].unf)
      else $error("underflow request in a match channel");
   AST_NO_MCD: assert property (!(irq_req[1].md || irq_req[1].mc || irq_req[2].md || irq_req[2].mc))
      else $error("match C or D request in an up/down channel");

   for (genvar c = 0; c < NCH; c++)
   begin : g_conv
      AST_CONV_CAUSE: assert property (conv_start_req[c] |-> $past(match_evt[c].ma))
         else $error("converter start without a channel A event");
      AST_CONV_PULSE: assert property (conv_start_req[c] && !match_evt[c].ma |=> !conv_start_req[c])
         else $error("converter start held longer than one cycle");
   end

endmodule : tcie_assertions

// ---- test/tcie_far_end.sv ----
// Behavioural converter trigger sink on the far side of the bank
`timescale 1ns/1ps
module tcie_far_end
   import tcie_pkg::*;
#(
   parameter int NCH = TCIE_NCH
)
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [NCH-1:0] conv_start_req,
   output logic [7:0]          conv_cnt [NCH]
);
   // Each high cycle is one conversion; a stuck request shows as an overcount
   always_ff @(posedge aclk)
   begin
      for (int c = 0; c < NCH; c++)
         conv_cnt[c] <= !aresetn ? 8'h00 : conv_cnt[c] + {7'h00, conv_start_req[c]};
   end

endmodule : tcie_far_end

// ---- test/tb_top.sv ----
// Self-checking bench for the timer interrupt enable bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
   import tcie_pkg::*;
();
   localparam int NCH = TCIE_NCH;
   localparam int TMO = 20000;

   logic        aclk;
   logic        aresetn;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq, ud;
   logic [7:0]  awaddr, araddr, em, fm;
   logic [31:0] wdata, rdata, rd_q;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [15:0] cnt      [NCH];
   tcie_match_s mev      [NCH];
   tcie_req_s   req      [NCH];
   logic [NCH-1:0] conv;
   logic [7:0]  conv_cnt [NCH];
   int          n_fail, compares, cyc;

   tcie_top #(.NCH(NCH), .CNT_W(TCIE_CNT_W)) uut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .channel_counter(cnt), .match_evt(mev), .irq_req(req), .conv_start_req(conv), .irq(irq)
   );

   tcie_far_end #(.NCH(NCH)) u_far
   (
      .aclk(aclk), .aresetn(aresetn), .conv_start_req(conv), .conv_cnt(conv_cnt)
   );

   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] ena(input int c);
      return TCIE_ENA_BASE + TCIE_WORD_STEP * 8'(c);
   endfunction : ena

   function automatic logic [7:0] sts(input int c);
      return TCIE_STS_BASE + TCIE_WORD_STEP * 8'(c);
   endfunction : sts

   // Address and data offered together; each released once its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (awvalid && awready)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd_q = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      `CHK(rd_q, {24'h00_0000, e})
      `CHK(rs, TCIE_RESP_OKAY)
   endtask : rchk

   task automatic evt(input int c, input tcie_match_s m);
      @(posedge aclk);
      mev[c] <= m;
      @(posedge aclk);
      mev[c] <= 4'h0;
   endtask : evt

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Hang guard
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == TMO)
      begin
         n_fail++;
         final_report;
      end
   end

   ////////////////////////////////////////////////////////////
   initial
   begin
      n_fail = 0;
      compares = 0;
      aresetn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      awaddr <= 8'h00;
      araddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'hF;
      cnt <= '{default: 16'h0000};
      mev <= '{default: 4'h0};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int c = 0; c < NCH; c++)
         rchk(ena(c), 8'h40);
      rd(8'h80);
      `CHK({rs, rd_q}, {TCIE_RESP_DEC, 32'h0000_0000})
      wr(8'h80, 8'hFF);
      `CHK(rs, TCIE_RESP_DEC)
      wstrb <= 4'h0;
      wr(ena(0), 8'hFF);
      wstrb <= 4'hF;
      rchk(ena(0), 8'h40);
      for (int c = 0; c < NCH; c++)
      begin
         ud = (c == 1 || c == 2);
         em = ud ? TCIE_ENA_MASK_UD : TCIE_ENA_MASK_MAT;
         fm = ud ? TCIE_FLG_MASK_UD : TCIE_FLG_MASK_MAT;
         wr(ena(c), 8'hFF);
         `CHK(rs, TCIE_RESP_OKAY)
         rchk(ena(c), em | 8'h40);
         wr(ena(c), 8'h00);
         // Channel A event with start disabled must not reach the converter
         evt(c, 4'hF);
         @(posedge aclk);
         cnt[c] <= TCIE_CNT_MAX;
         @(posedge aclk);
         cnt[c] <= TCIE_CNT_ZERO;
         repeat (2) @(posedge aclk);
         for (int b = 0; b < 6; b++)
         begin
            wr(ena(c), 8'(1 << b));
            repeat (2) @(posedge aclk);
            `CHK(req[c], 6'(1 << b) & fm[5:0])
         end
         wr(ena(c), 8'h3F);
         wr(sts(c), 8'hFF);
         // A zero written before any read must leave the flags alone
         wr(sts(c), 8'h00);
         rchk(sts(c), 8'hC0 | fm);
         wr(sts(c), 8'h00);
         rchk(sts(c), 8'hC0);
         repeat (2) @(posedge aclk);
         `CHK(req[c], 6'h00)
         wr(ena(c), 8'h80);
         evt(c, 4'h1);
         repeat (2) @(posedge aclk);
         `CHK(conv_cnt[c], 8'h01)
      end
      `CHK(irq, 1'b0)
      wr(TCIE_EVT_MASK, 8'h3F);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(TCIE_EVT_STS, 8'h3F);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(ena(0), 8'h81);
      evt(0, 4'h1);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(TCIE_EVT_MASK, 8'h00);
      repeat (4) @(posedge aclk);
      `CHK(irq, 1'b0)
      final_report;
   end

endmodule : tb_top

bind tcie_top tcie_assertions #(.NCH(NCH)) u_chk
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .match_evt(match_evt), .irq_req(irq_req), .conv_start_req(conv_start_req)
);
